// ===== core/lpnp_partner_np.sv
// lpnp_partner_np: partner next page ability register with avalon-mm slave
// assumes the receive side of negotiation presents a decoded page with a one-cycle strobe
//
// Overview of operation
// - bit 15 shows the partner's more-pages indication and resets to 0.
// - bit 14 shows whether the partner acknowledged our word and resets to 0.
// - the acknowledge bit is set only by the received pulse bursts, never by software.
// - bit 13 marks message page (1) or unformatted page (0) and resets to 1.
// - bit 12 shows whether the partner can comply with the message and resets to 0.
// - bit 11 holds the inverse of its own previous stored value, so it flips on each received page.
// - bits 10:0 carry the received code, a message code when bit 13 is set.
// - with bit 13 clear the code field is an unformatted page passed through unchanged.
// - after reset the code field reads the null page code 001.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
module lpnp_partner_np (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [lpnp_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic page_valid_in,
    input wire logic [15:0] page_word_in,
    output logic [15:0] partner_np_out,
    output logic page_seen_out
);
    typedef enum logic [1:0] {
        LPNP_IDLE = 2'b00,
        LPNP_ANSWER = 2'b01
    } lpnp_bus_e;

    logic [15:0] pnpa_q, pnpa_d;
    logic seen_q, seen_d;
    logic clr_seen_q, clr_seen_d;
    lpnp_bus_e state_q, state_d;
    logic [31:0] rdata_q, rdata_d;
    logic wait_q, wait_d;

    // word index straight from the word address
    function automatic logic [15:0] word_index(input logic [lpnp_pkg::ADDR_W-1:0] a);
        word_index = 16'(a);
    endfunction

    // page register decode
    function automatic logic hit_page(input logic [lpnp_pkg::ADDR_W-1:0] a);
        hit_page = (word_index(a) == lpnp_pkg::PNPA_IDX);
    endfunction

    // control and status decode
    function automatic logic hit_ctrl(input logic [lpnp_pkg::ADDR_W-1:0] a);
        hit_ctrl = (word_index(a) == lpnp_pkg::CTRL_IDX);
    endfunction

    // page register: fed only from the link side
    always_comb begin
        pnpa_d = pnpa_q;
        seen_d = seen_q;
        if (page_valid_in) begin
            pnpa_d[lpnp_pkg::MORE_POS] = page_word_in[lpnp_pkg::MORE_POS];
            pnpa_d[lpnp_pkg::ACK_POS] = page_word_in[lpnp_pkg::ACK_POS];
            pnpa_d[lpnp_pkg::MSG_POS] = page_word_in[lpnp_pkg::MSG_POS];
            pnpa_d[lpnp_pkg::COMPLY_POS] = page_word_in[lpnp_pkg::COMPLY_POS];
            // toggle stored as inverse of previous stored toggle
            pnpa_d[lpnp_pkg::TOG_POS] = ~pnpa_q[lpnp_pkg::TOG_POS];
            pnpa_d[lpnp_pkg::CODE_HI:0] = page_word_in[lpnp_pkg::CODE_HI:0];
        end
        // set wins over clear
        if (page_valid_in) begin
            seen_d = 1'b1;
        end else if (clr_seen_q) begin
            seen_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pnpa_q <= lpnp_pkg::PNPA_RST;
            seen_q <= 1'b0;
        end else begin
            pnpa_q <= pnpa_d;
            seen_q <= seen_d;
        end
    end

    // avalon slave: one wait cycle, then answer
    always_comb begin
        state_d = state_q;
        rdata_d = rdata_q;
        wait_d = 1'b1;
        clr_seen_d = 1'b0;
        unique case (state_q)
            LPNP_IDLE: begin
                if (avs_read_in || avs_write_in) begin
                    state_d = LPNP_ANSWER;
                    wait_d = 1'b0;
                    rdata_d = lpnp_pkg::UNMAPPED_RD;
                    if (avs_read_in) begin
                        if (hit_page(avs_address_in)) begin
                            rdata_d = {16'h0000, pnpa_q};
                        end else if (hit_ctrl(avs_address_in)) begin
                            rdata_d = {31'h0000_0000, seen_q};
                        end
                    end
                    // writing 1 to bit 0 of control clears the seen flag
                    if (avs_write_in && avs_byteenable_in[0]
                            && hit_ctrl(avs_address_in)) begin
                        clr_seen_d = avs_writedata_in[0];
                    end
                end
            end
            LPNP_ANSWER: begin
                state_d = LPNP_IDLE;
            end
            default: begin
                state_d = LPNP_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_q <= LPNP_IDLE;
            rdata_q <= 32'h0000_0000;
            wait_q <= 1'b1;
            clr_seen_q <= 1'b0;
        end else begin
            state_q <= state_d;
            rdata_q <= rdata_d;
            wait_q <= wait_d;
            clr_seen_q <= clr_seen_d;
        end
    end

    assign avs_readdata_out = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign partner_np_out = pnpa_q;
    assign page_seen_out = seen_q;

    // assertions
    // building blocks: page strobe, bus request taken, register hits
    sequence page_in_s;
        page_valid_in;
    endsequence

    sequence no_page_s;
        !page_valid_in;
    endsequence

    sequence bus_req_s;
        (avs_read_in || avs_write_in) && wait_q && state_q == LPNP_IDLE;
    endsequence

    sequence bus_quiet_s;
        !((avs_read_in || avs_write_in) && state_q == LPNP_IDLE);
    endsequence

    sequence page_rd_s;
        bus_req_s ##0 (avs_read_in && hit_page(avs_address_in));
    endsequence

    sequence ctrl_rd_s;
        bus_req_s ##0 (avs_read_in && hit_ctrl(avs_address_in));
    endsequence

    sequence other_rd_s;
        bus_req_s ##0 (avs_read_in && !hit_page(avs_address_in)
            && !hit_ctrl(avs_address_in));
    endsequence

    sequence any_wr_s;
        bus_req_s ##0 avs_write_in;
    endsequence

    sequence ctrl_clr_s;
        bus_req_s ##0 (avs_write_in && avs_byteenable_in[0]
            && hit_ctrl(avs_address_in) && avs_writedata_in[0]);
    endsequence

    sequence answer_s;
        !wait_q ##1 wait_q;
    endsequence

    property load_fields_p;
        @(posedge core_clk_in) disable iff (rst_in)
        page_in_s |=> (pnpa_q[lpnp_pkg::MORE_POS:lpnp_pkg::COMPLY_POS]
            == $past(page_word_in[lpnp_pkg::MORE_POS:lpnp_pkg::COMPLY_POS])
            && pnpa_q[lpnp_pkg::CODE_HI:0] == $past(page_word_in[lpnp_pkg::CODE_HI:0]));
    endproperty
    page_load_a: assert property (load_fields_p)
        else $error("page not loaded");

    page_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        no_page_s |=> $stable(pnpa_q))
        else $error("page word changed without page");

    more_flag_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        page_in_s |=> pnpa_q[lpnp_pkg::MORE_POS] == $past(page_word_in[lpnp_pkg::MORE_POS]))
        else $error("more pages flag wrong");

    ack_load_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        page_in_s |=> pnpa_q[lpnp_pkg::ACK_POS] == $past(page_word_in[lpnp_pkg::ACK_POS]))
        else $error("ack flag wrong");

    ack_hw_only_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        no_page_s |=> $stable(pnpa_q[lpnp_pkg::ACK_POS]))
        else $error("ack changed without page");

    ack_nowrite_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (avs_write_in && !page_valid_in)
            |=> pnpa_q[lpnp_pkg::ACK_POS] == $past(pnpa_q[lpnp_pkg::ACK_POS]))
        else $error("ack changed by write");

    msg_flag_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        page_in_s |=> pnpa_q[lpnp_pkg::MSG_POS] == $past(page_word_in[lpnp_pkg::MSG_POS]))
        else $error("message flag wrong");

    comply_flag_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        page_in_s |=> pnpa_q[lpnp_pkg::COMPLY_POS] == $past(page_word_in[lpnp_pkg::COMPLY_POS]))
        else $error("comply flag wrong");

    toggle_inv_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        page_in_s |=> pnpa_q[lpnp_pkg::TOG_POS] != $past(pnpa_q[lpnp_pkg::TOG_POS]))
        else $error("toggle not inverted");

    code_pass_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        page_in_s |=> pnpa_q[lpnp_pkg::CODE_HI:0] == $past(page_word_in[lpnp_pkg::CODE_HI:0]))
        else $error("code field wrong");

    code_raw_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (page_valid_in && !page_word_in[lpnp_pkg::MSG_POS])
            |=> pnpa_q[lpnp_pkg::CODE_HI:0] == $past(page_word_in[lpnp_pkg::CODE_HI:0]))
        else $error("unformatted code altered");

    reset_value_a: assert property (@(posedge core_clk_in)
        rst_in |=> pnpa_q[lpnp_pkg::CODE_HI:0] == lpnp_pkg::CODE_NULL)
        else $error("reset code wrong");

    reset_word_a: assert property (@(posedge core_clk_in)
        rst_in |=> pnpa_q == lpnp_pkg::PNPA_RST)
        else $error("reset word wrong");

    seen_set_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        page_in_s |=> seen_q)
        else $error("seen flag not set");

    seen_clear_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (!page_valid_in && clr_seen_q) |=> !seen_q)
        else $error("seen flag not cleared");

    seen_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (!page_valid_in && !clr_seen_q) |=> $stable(seen_q))
        else $error("seen flag changed on its own");

    clear_req_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ctrl_clr_s |=> clr_seen_q ##1 !clr_seen_q)
        else $error("clear request not one cycle");

    bus_answer_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        bus_req_s |=> answer_s)
        else $error("bus answer timing wrong");

    wait_single_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !wait_q |=> wait_q)
        else $error("wait low for more than one cycle");

    wait_idle_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        bus_quiet_s |=> wait_q)
        else $error("wait low without request");

    rdata_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        bus_quiet_s |=> $stable(avs_readdata_out))
        else $error("read data changed without request");

    write_rd_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        any_wr_s |=> avs_readdata_out == lpnp_pkg::UNMAPPED_RD)
        else $error("read data after write wrong");

    upper_zero_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        avs_readdata_out[31:16] == 16'h0000)
        else $error("upper read data not zero");

    reset_bus_a: assert property (@(posedge core_clk_in)
        rst_in |=> (wait_q && state_q == LPNP_IDLE && !seen_q && !clr_seen_q))
        else $error("bus side reset state wrong");

    property read_page_p;
        @(posedge core_clk_in) disable iff (rst_in)
        page_rd_s |=> avs_readdata_out == {16'h0000, $past(pnpa_q)};
    endproperty
    read_page_a: assert property (read_page_p)
        else $error("page register read wrong");

    property read_ctrl_p;
        @(posedge core_clk_in) disable iff (rst_in)
        ctrl_rd_s |=> avs_readdata_out == {31'h0000_0000, $past(seen_q)};
    endproperty
    read_ctrl_a: assert property (read_ctrl_p)
        else $error("control read wrong");

    property read_other_p;
        @(posedge core_clk_in) disable iff (rst_in)
        other_rd_s |=> avs_readdata_out == lpnp_pkg::UNMAPPED_RD;
    endproperty
    read_other_a: assert property (read_other_p)
        else $error("unmapped read not zero");
endmodule

// ===== core/lpnp_pkg.sv
// lpnp_pkg: offsets, field positions and reset values for the partner next page register
// assumes a 32-bit avalon-mm bus addressed in words
package lpnp_pkg;
    localparam logic [3:0] ADDR_W = 4'h4;
    // word addresses of the page register and the control and status word
    localparam logic [15:0] PNPA_IDX = 16'h0008;
    localparam logic [15:0] CTRL_IDX = 16'h0009;
    localparam int MORE_POS = 15;
    localparam int ACK_POS = 14;
    localparam int MSG_POS = 13;
    localparam int COMPLY_POS = 12;
    localparam int TOG_POS = 11;
    localparam int CODE_HI = 10;
    localparam logic [15:0] PNPA_RST = 16'h2001;
    localparam logic [10:0] CODE_NULL = 11'h001;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
endpackage

// ===== tb/lpnp_lp_model.sv
// lpnp_lp_model: link partner side, hands over complete next pages
// assumes pages are taken on the rising clock edge
`timescale 1ns/10ps
module lpnp_lp_model (
    input wire logic core_clk_in,
    output logic page_valid_out,
    output logic [15:0] page_word_out
);
    initial begin
        page_valid_out = 1'b0;
        page_word_out = 16'h0000;
    end
    task automatic send(input logic [15:0] w);
        @(posedge core_clk_in);
        page_valid_out <= 1'b1;
        page_word_out <= w;
        @(posedge core_clk_in);
        page_valid_out <= 1'b0;
        // word no longer valid: show its inverse
        page_word_out <= ~w;
    endtask
endmodule

// ===== tb/lpnp_partner_np_tb_top.sv
// lpnp_partner_np_tb_top: reset, corner and random pages, bus access
// assumes word addresses: page register at 8, control and status at 9
`timescale 1ns/10ps
module lpnp_partner_np_tb_top;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [lpnp_pkg::ADDR_W-1:0] avs_address_in = 4'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out, rd;
    logic avs_waitrequest_out, page_valid_in, page_seen_out;
    logic [15:0] page_word_in, partner_np_out, exp_q;
    int n_fail = 0;
    int compares = 0;
    always #10 core_clk_in = ~core_clk_in;
    lpnp_lp_model i_lpnp_lp_model (.core_clk_in(core_clk_in),
        .page_valid_out(page_valid_in), .page_word_out(page_word_in));
    lpnp_partner_np i_lpnp_partner_np (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .page_valid_in(page_valid_in),
        .page_word_in(page_word_in), .partner_np_out(partner_np_out),
        .page_seen_out(page_seen_out));
    function automatic logic [15:0] nxt(input logic [15:0] p, input logic [15:0] w);
        return {w[15:12], ~p[11], w[10:0]};
    endfunction
    task automatic conclude;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t word got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t bus got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= ~wr;
        avs_write_in <= wr;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        if (avs_waitrequest_out !== 1'b0) begin
            n_fail++;
            $display("[FAIL] %0t bus answer timed out", $time);
            conclude();
        end else begin
            rd = avs_readdata_out;
            avs_read_in <= 1'b0;
            avs_write_in <= 1'b0;
        end
    endtask
    task automatic page(input logic [15:0] w);
        i_lpnp_lp_model.send(w);
        exp_q = nxt(exp_q, w);
        @(negedge core_clk_in);
        chk16(partner_np_out, exp_q);
        chk16({15'h0, page_seen_out}, 16'h0001);
    endtask
    task automatic rchk;
        exp_q = lpnp_pkg::PNPA_RST;
        @(negedge core_clk_in);
        chk16(partner_np_out, lpnp_pkg::PNPA_RST);
        chk16({15'h0, page_seen_out}, 16'h0000);
    endtask
    initial begin
        void'($urandom(32'ha8a8));
        repeat (5) @(posedge core_clk_in);
        rst_in <= 1'b0;
        rchk();
        $display("test reset done");
        page(16'hffff);
        page(16'h0000);
        page(16'h4000);
        repeat (24) page(16'($urandom));
        $display("test pages done");
        bus(1'b1, 4'h8, 32'hffff_ffff);
        bus(1'b0, 4'h8, 32'h0);
        chk32(rd, {16'h0000, exp_q});
        bus(1'b0, 4'h9, 32'h0);
        chk32(rd, 32'h0000_0001);
        bus(1'b1, 4'h9, 32'h0000_0001);
        bus(1'b0, 4'h9, 32'h0);
        chk32(rd, 32'h0000_0000);
        repeat (3) begin
            bus(1'b0, 4'($urandom) & 4'h7, 32'h0);
            chk32(rd, lpnp_pkg::UNMAPPED_RD);
        end
        @(negedge core_clk_in);
        chk16(partner_np_out, exp_q);
        $display("test bus done");
        @(posedge core_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        rst_in <= 1'b0;
        rchk();
        page(16'($urandom));
        $display("test second reset done");
        conclude();
    end
endmodule
